// [design/ftc_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package ftc_pkg;
    // special function register map
    localparam logic [7:0] ADDR_SCALE = 8'h00_B6;
    localparam logic [7:0] ADDR_LIMIT = 8'h00_BE;
    localparam logic [7:0] ADDR_CACHE = 8'h00_E3;
    localparam logic [7:0] PAGE_FLASH = 8'h00_0F;
    // reset values
    localparam logic [7:0] RST_SCALE = 8'h00_00;
    localparam logic [3:0] RST_LIMIT = 4'h0_F;
    localparam logic [7:0] RST_CACHE = 8'h00_20;
    // field positions
    localparam int BIT_READ_TIME = 4;
    localparam int BIT_EW_TIME = 1;
    localparam int BIT_PREFETCH = 5;
    localparam int BIT_BLOCK_WR = 0;
    // timing, ns and derived clk_sys ticks
    localparam int SYS_PERIOD_NS = 10;
    localparam int CAP_BASE_NS = 5;
    localparam int CAP_STEP_NS = 5;
    localparam int SLOW_PERIOD_NS = 80;
    localparam int SLOW_DIV = (SLOW_PERIOD_NS + SYS_PERIOD_NS - 1)
                              / SYS_PERIOD_NS;

    typedef struct packed {
        logic req;
        logic [15:0] addr;
        logic [7:0] data;
    } ftc_wr_t;

    typedef struct packed {
        logic active;
        logic long_timing;
        logic [15:0] addr;
        logic [15:0] data;
        logic [1:0] byte_en;
    } ftc_prog_t;

    // longest strobe in whole ticks, rounded down, at least one
    function automatic logic [4:0] cap_ticks(input logic [3:0] period);
        int t;
        t = (CAP_BASE_NS + CAP_STEP_NS * int'(period)) / SYS_PERIOD_NS;
        if (t < 1) begin
            t = 1;
        end
        return 5'(t);
    endfunction
endpackage

// [design/ftc_strobe_timer.sv]
`timescale 1ns/1ns
module ftc_strobe_timer (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic rd_req,
    input wire logic read_time_select,
    input wire logic [3:0] period,
    input wire logic [3:0] sysclk_div,
    output logic rd_strobe,
    output logic array_low_power,
    output logic rd_busy
);
    typedef struct packed {
        logic [4:0] total_left;
        logic [4:0] strobe_left;
        logic strobe;
        logic low_power;
        logic busy;
    } ftc_tmr_t;

    ftc_tmr_t st_ff;
    ftc_tmr_t nxt_st;
    logic [4:0] total;
    logic [4:0] cap;
    logic capped;

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        total = read_time_select ? 5'({sysclk_div, 1'b0})
                                 : 5'(sysclk_div);
        cap = ftc_pkg::cap_ticks(period);
        // fast clock with one-clock strobe: the period has no say
        capped = !(int'(sysclk_div) < ftc_pkg::SLOW_DIV
                   && !read_time_select);
        if (st_ff.total_left != 5'h0_0) begin
            nxt_st.total_left = st_ff.total_left - 5'h0_1;
            if (st_ff.strobe_left != 5'h0_0) begin
                nxt_st.strobe_left = st_ff.strobe_left - 5'h0_1;
            end
        end else if (rd_req && sysclk_div != 4'h0) begin
            nxt_st.total_left = total;
            nxt_st.strobe_left = (capped && cap < total) ? cap : total;
        end
        nxt_st.strobe = nxt_st.strobe_left != 5'h0_0;
        // low power from strobe removal to the end of the cycle
        nxt_st.low_power = nxt_st.total_left != 5'h0_0
                           && nxt_st.strobe_left == 5'h0_0;
        nxt_st.busy = nxt_st.total_left != 5'h0_0;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rd_strobe = st_ff.strobe;
    assign array_low_power = st_ff.low_power;
    assign rd_busy = st_ff.busy;

    //////////////////////////////////////////////////////////////////////////
    a_strobe_full_one: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (rd_req && !rd_busy && !read_time_select
         && sysclk_div == 4'h1) |=> rd_strobe ##1 !rd_strobe)
        else $error("one-clock strobe length wrong");
    a_strobe_cap_width: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (rd_req && !rd_busy && read_time_select && sysclk_div == 4'h4
         && period == 4'h3) |=> rd_strobe[*2] ##1 array_low_power[*6]
        ##1 !array_low_power)
        else $error("capped strobe width wrong");
    a_strobe_no_cap: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (rd_req && !rd_busy && !read_time_select && sysclk_div == 4'h4
         && period == 4'h0) |=> rd_strobe[*4] ##1 !rd_strobe)
        else $error("period limited a fast one-clock strobe");
    a_low_power_excl: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $fell(rd_strobe) && rd_busy |-> array_low_power)
        else $error("array not in low power after strobe");
endmodule // ftc_strobe_timer

// [design/ftc_ctrl.sv]
`timescale 1ns/1ns
module ftc_ctrl #(
    parameter int unsigned PROG_SHORT_CYC = 1000,
    parameter int unsigned PROG_LONG_CYC = 2000
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [3:0] sysclk_div,
    input wire logic rd_req,
    output logic rd_strobe,
    output logic array_low_power,
    output logic rd_busy,
    output logic prefetch_enable,
    input wire ftc_pkg::ftc_wr_t wr_in,
    output logic wr_busy,
    output ftc_pkg::ftc_prog_t prog
);
    typedef enum logic {WR_IDLE, WR_PROG} ftc_wr_state_t;

    typedef struct packed {
        logic [7:0] scale;
        logic [3:0] limit;
        logic [7:0] cache;
        logic [7:0] rdata;
        ftc_wr_state_t wst;
        logic [15:0] prog_cnt;
        logic held_valid;
        logic [15:0] held_addr;
        logic [7:0] held_data;
        ftc_pkg::ftc_prog_t prog;
    } ftc_state_t;

    ftc_state_t st_ff;
    ftc_state_t nxt_st;
    logic read_time_select;
    logic erase_write_time_select;
    logic block_write_enable;

    // flash-page registers only answer on the flash page
    function automatic logic hit(input logic [7:0] a, input logic [7:0] pg,
                                 input logic [7:0] want, input logic any);
        return a == want && (any || pg == ftc_pkg::PAGE_FLASH);
    endfunction

    assign read_time_select = st_ff.scale[ftc_pkg::BIT_READ_TIME];
    assign erase_write_time_select = st_ff.scale[ftc_pkg::BIT_EW_TIME];
    assign block_write_enable = st_ff.cache[ftc_pkg::BIT_BLOCK_WR];

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        // register writes; reserved scale and cache bits stored but drive nothing, limit keeps bits 3:0 only
        if (sfr_wr) begin
            if (hit(sfr_addr, sfr_page, ftc_pkg::ADDR_SCALE, 1'b1)) begin
                nxt_st.scale = sfr_wdata;
            end
            if (hit(sfr_addr, sfr_page, ftc_pkg::ADDR_LIMIT, 1'b0)) begin
                nxt_st.limit = sfr_wdata[3:0];
            end
            if (hit(sfr_addr, sfr_page, ftc_pkg::ADDR_CACHE, 1'b0)) begin
                nxt_st.cache = sfr_wdata;
            end
        end
        if (sfr_rd) begin
            if (hit(sfr_addr, sfr_page, ftc_pkg::ADDR_SCALE, 1'b1)) begin
                nxt_st.rdata = st_ff.scale;
            end else if (hit(sfr_addr, sfr_page, ftc_pkg::ADDR_LIMIT,
                             1'b0)) begin
                nxt_st.rdata = {4'h0, st_ff.limit};
            end else if (hit(sfr_addr, sfr_page, ftc_pkg::ADDR_CACHE,
                             1'b0)) begin
                nxt_st.rdata = st_ff.cache;
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end
        // flash programming; requests while busy are dropped
        unique case (st_ff.wst)
            WR_IDLE: begin
                nxt_st.prog.active = 1'b0;
                if (wr_in.req) begin
                    // timing chosen at each request; a pair takes the second byte's
                    nxt_st.prog.long_timing = erase_write_time_select;
                    nxt_st.prog_cnt = erase_write_time_select
                        ? 16'(PROG_LONG_CYC)
                        : 16'(PROG_SHORT_CYC);
                    nxt_st.prog.addr = wr_in.addr;
                    nxt_st.prog.data = {wr_in.data, wr_in.data};
                    nxt_st.prog.byte_en = wr_in.addr[0] ? 2'b10 : 2'b01;
                    if (block_write_enable && !wr_in.addr[0]) begin
                        // hold low byte until its partner arrives
                        nxt_st.held_valid = 1'b1;
                        nxt_st.held_addr = wr_in.addr;
                        nxt_st.held_data = wr_in.data;
                    end else begin
                        if (block_write_enable && st_ff.held_valid
                            && st_ff.held_addr[15:1]
                               == wr_in.addr[15:1]) begin
                            nxt_st.prog.addr = st_ff.held_addr;
                            nxt_st.prog.data = {wr_in.data,
                                                st_ff.held_data};
                            nxt_st.prog.byte_en = 2'b11;
                        end
                        nxt_st.held_valid = 1'b0;
                        nxt_st.prog.active = 1'b1;
                        nxt_st.wst = WR_PROG;
                    end
                end
            end
            WR_PROG: begin
                if (st_ff.prog_cnt <= 16'h0001) begin
                    nxt_st.prog.active = 1'b0;
                    nxt_st.wst = WR_IDLE;
                end else begin
                    nxt_st.prog_cnt = st_ff.prog_cnt - 16'h0001;
                end
            end
        endcase
        // single-byte mode never leaves a byte waiting
        if (!block_write_enable && !wr_in.req) begin
            nxt_st.held_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{scale: ftc_pkg::RST_SCALE, limit: ftc_pkg::RST_LIMIT,
                       cache: ftc_pkg::RST_CACHE, rdata: 8'h00,
                       wst: WR_IDLE, prog_cnt: 16'h0000,
                       held_valid: 1'b0, held_addr: 16'h0000,
                       held_data: 8'h00, prog: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    ftc_strobe_timer u_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .rd_req(rd_req),
        .read_time_select(read_time_select),
        .period(st_ff.limit),
        .sysclk_div(sysclk_div),
        .rd_strobe(rd_strobe),
        .array_low_power(array_low_power),
        .rd_busy(rd_busy)
    );

    assign sfr_rdata = st_ff.rdata;
    assign prefetch_enable = st_ff.cache[ftc_pkg::BIT_PREFETCH];
    assign wr_busy = st_ff.wst == WR_PROG;
    assign prog = st_ff.prog;

    //////////////////////////////////////////////////////////////////////////
    sequence s_pair_first;
        wr_in.req && !wr_busy && block_write_enable && !wr_in.addr[0];
    endsequence
    sequence s_pair_second;
        wr_in.req && wr_in.addr[0] && !wr_busy;
    endsequence

    a_limit_high_zero: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        sfr_rd && sfr_addr == ftc_pkg::ADDR_LIMIT
        && sfr_page == ftc_pkg::PAGE_FLASH |=> sfr_rdata[7:4] == 4'h0)
        else $error("strobe limit upper nibble not zero");
    a_prefetch_follows: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        sfr_wr && sfr_addr == ftc_pkg::ADDR_CACHE
        && sfr_page == ftc_pkg::PAGE_FLASH
        |=> prefetch_enable == $past(sfr_wdata[5]))
        else $error("prefetch enable did not follow write");
    a_block_single: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        wr_in.req && !wr_busy && !block_write_enable
        |=> prog.active && prog.byte_en != 2'b11)
        else $error("single-byte write not programmed alone");
    a_block_pair: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        s_pair_first ##1 (s_pair_second and (block_write_enable
        && wr_in.addr[15:1] == $past(wr_in.addr[15:1])))
        |=> prog.active && prog.byte_en == 2'b11)
        else $error("byte pair not programmed together");
    a_ew_timing: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $rose(prog.active) |-> prog.long_timing == $past(erase_write_time_select))
        else $error("program timing does not match select");
endmodule // ftc_ctrl

// [testbench/ftc_flash_model.sv]
`timescale 1ns/1ns
module ftc_flash_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic rd_strobe,
    input wire logic array_low_power,
    input wire ftc_pkg::ftc_prog_t prog,
    output logic [7:0] strobe_len_ff,
    output logic [7:0] lp_len_ff,
    output logic [15:0] act_len_ff,
    output logic [7:0] prog_cnt_ff,
    output ftc_pkg::ftc_prog_t last_prog_ff,
    output logic overlap_ff
);
    logic strobe_prev_ff;
    logic act_prev_ff;
    logic [7:0] mem_ff [0:511];

    //////////////////////////////////////////////////////////////////////////
    // array side: measures each strobe and program window as it arrives
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            strobe_prev_ff <= 1'b0;
            act_prev_ff <= 1'b0;
            strobe_len_ff <= 8'h00;
            lp_len_ff <= 8'h00;
            act_len_ff <= 16'h0000;
            prog_cnt_ff <= 8'h00;
            last_prog_ff <= '0;
            overlap_ff <= 1'b0;
        end else begin
            strobe_prev_ff <= rd_strobe;
            act_prev_ff <= prog.active;
            if (rd_strobe && !strobe_prev_ff) begin
                strobe_len_ff <= 8'h01;
                lp_len_ff <= 8'h00;
            end else if (rd_strobe) begin
                strobe_len_ff <= strobe_len_ff + 8'h01;
            end else if (array_low_power) begin
                lp_len_ff <= lp_len_ff + 8'h01;
            end
            // strobe and low power together would starve the sense amps
            if (rd_strobe && array_low_power) begin
                overlap_ff <= 1'b1;
            end
            if (prog.active && !act_prev_ff) begin
                act_len_ff <= 16'h0001;
                last_prog_ff <= prog;
                prog_cnt_ff <= prog_cnt_ff + 8'h01;
                if (prog.byte_en[0]) begin
                    mem_ff[{prog.addr[8:1], 1'b0}] <= prog.data[7:0];
                end
                if (prog.byte_en[1]) begin
                    mem_ff[{prog.addr[8:1], 1'b1}] <= prog.data[15:8];
                end
            end else if (prog.active) begin
                act_len_ff <= act_len_ff + 16'h0001;
            end
        end
    end
endmodule // ftc_flash_model

// [testbench/flash_timing_cache_ctrl_tb.sv]
`timescale 1ns/1ns
module flash_timing_cache_ctrl_tb;
    logic clk_sys, nrst, sfr_wr, sfr_rd, rd_req, overlap;
    logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata;
    logic [3:0] sysclk_div;
    logic rd_strobe, array_low_power, rd_busy, prefetch_enable, wr_busy;
    ftc_pkg::ftc_wr_t wr_in;
    ftc_pkg::ftc_prog_t prog, last_prog;
    logic [7:0] strobe_len, lp_len, prog_cnt, n0;
    logic [15:0] act_len;
    int failures, checked;
    localparam logic [7:0] PG = ftc_pkg::PAGE_FLASH;

    ftc_ctrl #(.PROG_SHORT_CYC(3), .PROG_LONG_CYC(6)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sysclk_div(sysclk_div), .rd_req(rd_req), .rd_strobe(rd_strobe),
        .array_low_power(array_low_power), .rd_busy(rd_busy),
        .prefetch_enable(prefetch_enable), .wr_in(wr_in),
        .wr_busy(wr_busy), .prog(prog));

    ftc_flash_model FLASH (
        .clk_sys(clk_sys), .nrst(nrst), .rd_strobe(rd_strobe),
        .array_low_power(array_low_power), .prog(prog),
        .strobe_len_ff(strobe_len), .lp_len_ff(lp_len),
        .act_len_ff(act_len), .prog_cnt_ff(prog_cnt),
        .last_prog_ff(last_prog), .overlap_ff(overlap));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    //////////////////////////////////////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task sfr_write(input logic [7:0] a, input logic [7:0] p,
                   input logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_page = p;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [7:0] p,
                input logic [7:0] exp);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_page = p;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        check({8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // bounded wait for a busy flag to drop
    task wait_idle(input logic wr_side);
        int n;
        n = 0;
        while ((wr_side ? wr_busy : rd_busy) !== 1'b0) begin
            @(negedge clk_sys);
            n++;
            if (n > 60) begin
                failures++;
                final_report();
            end
        end
        @(negedge clk_sys);
    endtask

    task do_read(input logic sel, input logic [3:0] div,
                 input logic [3:0] per);
        logic [7:0] w, cap, s;
        sfr_write(ftc_pkg::ADDR_SCALE, 8'h00, sel ? 8'h10 : 8'h00);
        sfr_write(ftc_pkg::ADDR_LIMIT, ftc_pkg::PAGE_FLASH, {4'h0, per});
        sysclk_div = div;
        @(negedge clk_sys);
        rd_req = 1'b1;
        @(negedge clk_sys);
        rd_req = 1'b0;
        wait_idle(1'b0);
        w = sel ? 8'(2 * div) : 8'(div);
        cap = 8'((5 + 5 * per) / 10);
        if (cap < 8'h01) begin
            cap = 8'h01;
        end
        s = (!sel && div < 4'h8) ? w : ((w < cap) ? w : cap);
        check(16'(strobe_len), 16'(s));
        check(16'(lp_len), 16'(w - s));
    endtask

    task do_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        wr_in = '{req: 1'b1, addr: a, data: d};
        @(negedge clk_sys);
        wr_in.req = 1'b0;
        wait_idle(1'b1);
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        checked = 0;
        nrst = 1'b0;
        {sfr_wr, sfr_rd, rd_req} = 3'b000;
        {sfr_addr, sfr_page, sfr_wdata} = 24'h0000_00;
        sysclk_div = 4'h4;
        wr_in = '0;
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        rd_chk(ftc_pkg::ADDR_SCALE, 8'h00, 8'h00);
        rd_chk(ftc_pkg::ADDR_LIMIT, PG, 8'h0F);
        rd_chk(ftc_pkg::ADDR_CACHE, PG, 8'h20);
        check(16'(prefetch_enable), 16'h0001);
        sfr_write(ftc_pkg::ADDR_LIMIT, PG, 8'hF3);
        rd_chk(ftc_pkg::ADDR_LIMIT, PG, 8'h03);
        rd_chk(ftc_pkg::ADDR_LIMIT, 8'h00, 8'h00);
        rd_chk(8'h55, PG, 8'h00);
        // reserved bits left at zero, both select bits set
        sfr_write(ftc_pkg::ADDR_SCALE, 8'h00, 8'h12);
        rd_chk(ftc_pkg::ADDR_SCALE, 8'h00, 8'h12);
        sfr_write(ftc_pkg::ADDR_CACHE, PG, 8'h00);
        check(16'(prefetch_enable), 16'h0000);
        sfr_write(ftc_pkg::ADDR_CACHE, PG, 8'h20);
        check(16'(prefetch_enable), 16'h0001);
        do_read(1'b0, 4'h4, 4'h0);
        do_read(1'b0, 4'h1, 4'h0);
        do_read(1'b1, 4'h4, 4'h3);
        do_read(1'b0, 4'hA, 4'h3);
        do_read(1'b1, 4'h2, 4'hF);
        do_read(1'b1, 4'h1, 4'h0);
        check(16'(overlap), 16'h0000);
        sfr_write(ftc_pkg::ADDR_SCALE, 8'h00, 8'h00);
        do_write(16'h0100, 8'h5A);
        check(act_len, 16'h0003);
        check(16'(last_prog.long_timing), 16'h0000);
        check(16'(last_prog.byte_en), 16'h0001);
        check(16'(last_prog.data[7:0]), 16'h005A);
        sfr_write(ftc_pkg::ADDR_SCALE, 8'h00, 8'h02);
        do_write(16'h0101, 8'hA5);
        check(act_len, 16'h0006);
        check(16'(last_prog.long_timing), 16'h0001);
        check(16'(last_prog.byte_en), 16'h0002);
        check(16'(last_prog.data[15:8]), 16'h00A5);
        sfr_write(ftc_pkg::ADDR_CACHE, PG, 8'h21);
        n0 = prog_cnt;
        do_write(16'h0200, 8'h11);
        check(16'(prog_cnt), 16'(n0));
        do_write(16'h0201, 8'h22);
        check(16'(prog_cnt), 16'(n0 + 8'h01));
        check(16'(last_prog.byte_en), 16'h0003);
        check(last_prog.data, 16'h2211);
        check(last_prog.addr, 16'h0200);
        // pair on back-to-back cycles, req held high between them
        @(negedge clk_sys);
        wr_in = '{req: 1'b1, addr: 16'h0300, data: 8'h33};
        @(negedge clk_sys);
        wr_in = '{req: 1'b1, addr: 16'h0301, data: 8'h44};
        @(negedge clk_sys);
        wr_in.req = 1'b0;
        wait_idle(1'b1);
        check(16'(prog_cnt), 16'(n0 + 8'h02));
        check(16'(last_prog.byte_en), 16'h0003);
        check(last_prog.data, 16'h4433);
        check(last_prog.addr, 16'h0300);
        final_report();
    end
endmodule // flash_timing_cache_ctrl_tb
